// >>> core/crp_pkg.sv
//--------------------------------------------------------------------
// Purpose: Constants for the CMOS clock and RAM port block
// Assumes: Clock of 250 MHz, period 4 ns
// Notes:   Port addresses, CMOS offsets, bit positions, timing
//--------------------------------------------------------------------
package crp_pkg;
   // -----------------------------------------------------------------
   // I/O port addresses
   // -----------------------------------------------------------------
   localparam logic [15:0] P_LOW_INDEX   = 16'h0070;
   localparam logic [15:0] P_LOW_DATA    = 16'h0071;
   localparam logic [15:0] P_UP_INDEX    = 16'h0074;
   localparam logic [15:0] P_UP_DATA     = 16'h0075;
   // -----------------------------------------------------------------
   // CMOS offsets
   // -----------------------------------------------------------------
   localparam logic [7:0]  OFF_SEC       = 8'h00;
   localparam logic [7:0]  OFF_SEC_AL    = 8'h01;
   localparam logic [7:0]  OFF_MIN       = 8'h02;
   localparam logic [7:0]  OFF_MIN_AL    = 8'h03;
   localparam logic [7:0]  OFF_HOUR      = 8'h04;
   localparam logic [7:0]  OFF_HOUR_AL   = 8'h05;
   localparam logic [7:0]  OFF_WDAY      = 8'h06;
   localparam logic [7:0]  OFF_MDAY      = 8'h07;
   localparam logic [7:0]  OFF_MONTH     = 8'h08;
   localparam logic [7:0]  OFF_YEAR      = 8'h09;
   localparam logic [7:0]  OFF_REG_A     = 8'h0a;
   localparam logic [7:0]  OFF_REG_B     = 8'h0b;
   localparam logic [7:0]  OFF_REG_C     = 8'h0c;
   localparam logic [7:0]  OFF_REG_D     = 8'h0d;
   localparam logic [7:0]  OFF_DATE_AL   = 8'h7d;
   localparam logic [7:0]  OFF_MONTH_AL  = 8'h7e;
   localparam logic [7:0]  OFF_CENTURY   = 8'h7f;
   // -----------------------------------------------------------------
   // Field positions and codes
   // -----------------------------------------------------------------
   localparam int          NMI_GATE_BIT  = 7;
   localparam int          A_UIP_BIT     = 7;
   localparam int          B_SET_BIT     = 7;
   localparam int          B_PIE_BIT     = 6;
   localparam int          B_AIE_BIT     = 5;
   localparam int          B_UIE_BIT     = 4;
   localparam int          B_DM_BIT      = 2;
   localparam int          B_H24_BIT     = 1;
   localparam int          HOUR_PM_BIT   = 7;
   localparam logic [2:0]  DIV_RUN       = 3'b010;
   localparam logic [7:0]  ALARM_ANY     = 8'hc0;
   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic        NMI_GATE_RST  = 1'b1;
   localparam logic [7:0]  REG_A_RST     = 8'h20;
   localparam logic [7:0]  REG_B_RST     = 8'h02;
   localparam logic [7:0]  BYTE_RST      = 8'h00;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int          CLK_PERIOD_NS = 4;
   localparam int          SECOND_NS     = 1000000000;
   localparam int          UIP_NS        = 244000;
   localparam int          BASE_HZ       = 32768;
   localparam int          SEC_CYC       = SECOND_NS / CLK_PERIOD_NS;
   localparam int          UIP_CYC       = UIP_NS / CLK_PERIOD_NS;
   localparam int          BASE_CYC      = SEC_CYC / BASE_HZ;
endpackage : crp_pkg

// >>> core/crp_rtc_port.sv
//--------------------------------------------------------------------
// Purpose: CMOS clock and 256-byte RAM behind two index/data pairs
// Assumes: Host I/O cycles as one-cycle strobes on i_clk
// Notes:   Internal reads answer one cycle after the strobe, forwarded reads two
//--------------------------------------------------------------------
// What this block does
// R1: Index bit 7 gates NMI on SERR
// R2: Lower index bits 6:0 select lower bytes
// R3: Lower pair internal, else forwarded externally
// R4: Upper pair 8-bit index, needs enable
// R5: Upper pair reaches all 256 bytes when enabled
// R6: Clock bytes 00-0D, 7D-7F; rest storage
// R7: Seconds, minutes and alarms count 0-59
// R8: Hours 1-12 with PM, or 0-23
// R9: Weekday 1-7, month day 1-31
// R10: Month 1-12, year 0-99
// R11: Date, month alarms and century byte
// R12: Register A bit 7 update busy, read-only
// R13: Divider 010 alone runs the clock
// R14: Rate select sets periodic flag period
// R15: Register B bit 7 inhibits updates
// R16: Periodic, alarm, update interrupt enables; spare bit
// R17: Binary select, 24-hour select, DST enable (stored only, no DST change made)
// R18: Register C summary, flags, low zeros
// R19: Register D battery good, low zeros
// R20: Summary from enabled flags; read clears
// R21: Software sets index, inhibits before loading
`timescale 1ns/100ps
module crp_rtc_port #(
   parameter int SEC_CYCLES  = crp_pkg::SEC_CYC,
   parameter int UIP_CYCLES  = crp_pkg::UIP_CYC,
   parameter int BASE_CYCLES = crp_pkg::BASE_CYC
) (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic [15:0] i_io_addr,
   input  wire logic        i_io_wr,
   input  wire logic        i_io_rd,
   input  wire logic [7:0]  i_io_wdata,
   input  wire logic        i_internal_clock_select,
   input  wire logic        i_upper_pair_access_enable,
   input  wire logic        i_serr_n,
   input  wire logic        i_battery_good,
   input  wire logic [7:0]  i_ext_rdata,
   output logic      [7:0]  o_io_rdata,
   output logic             o_io_rvalid,
   output logic             o_nmi,
   output logic             o_rtc_irq,
   output logic             o_ext_wr,
   output logic             o_ext_rd,
   output logic             o_ext_data_sel,
   output logic      [7:0]  o_ext_wdata
);
   import crp_pkg::*;

   localparam int SW = $clog2(SEC_CYCLES);
   localparam int BW = $clog2(BASE_CYCLES);

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic [7:0] to_bin(input logic [7:0] v,
                                         input logic bcd);
      to_bin = bcd ? 8'(v[7:4]) * 8'd10 + 8'(v[3:0]) : v;
   endfunction : to_bin

   function automatic logic [7:0] fr_bin(input logic [7:0] v,
                                         input logic bcd);
      fr_bin = bcd ? {4'(v / 8'd10), 4'(v % 8'd10)} : v;
   endfunction : fr_bin

   function automatic logic [7:0] month_len(input logic [7:0] mo,
                                            input logic [7:0] yr);
      case (mo)
         8'd2:    month_len = (yr[1:0] == 2'h0) ? 8'd29 : 8'd28;
         8'd4, 8'd6, 8'd9, 8'd11: month_len = 8'd30;
         default: month_len = 8'd31;
      endcase
   endfunction : month_len

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic [7:0]    mem_r [256];
   logic [7:0]    mem_nxt [256];
   logic          nmi_gate_r, nmi_gate_nxt;
   logic [6:0]    idx_lo_r, idx_lo_nxt;
   logic [7:0]    idx_up_r, idx_up_nxt;
   logic [7:0]    rdata_r, rdata_nxt;
   logic          rvalid_r, rvalid_nxt;
   logic          nmi_r, nmi_nxt;
   logic          ext_wr_r, ext_wr_nxt, ext_rd_r, ext_rd_nxt;
   logic          ext_sel_r, ext_sel_nxt;
   logic [7:0]    ext_wd_r, ext_wd_nxt;
   logic [1:0]    serr_s_r, serr_s_nxt, batt_s_r, batt_s_nxt;
   logic [7:0]    ext_s1_r, ext_s2_r, ext_s1_nxt, ext_s2_nxt;
   logic [SW-1:0] sec_cnt_r, sec_cnt_nxt;
   logic [BW-1:0] base_cnt_r, base_cnt_nxt;
   logic [14:0]   per_cnt_r, per_cnt_nxt;
   logic [2:0]    flags_r, flags_nxt;
   logic          irq_r, irq_nxt;
   logic          uip_r, uip_nxt;
   logic          lo_idx, lo_dat, up_idx, up_dat, lo_int, lo_fwd;
   logic          mem_wr, mem_rd, upd_tick, running, set_inh, per_ev;
   logic [7:0]    acc_addr, rd_byte, reg_a, reg_b;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   // -----------------------------------------------------------------
   // Port decode and host access
   // -----------------------------------------------------------------
   always_comb begin
      reg_a    = mem_r[OFF_REG_A];
      reg_b    = mem_r[OFF_REG_B];
      lo_idx   = i_io_addr == P_LOW_INDEX;
      lo_dat   = i_io_addr == P_LOW_DATA;
      up_idx   = (i_io_addr == P_UP_INDEX) && i_upper_pair_access_enable;
      up_dat   = (i_io_addr == P_UP_DATA) && i_upper_pair_access_enable;
      lo_int   = (lo_idx || lo_dat) && i_internal_clock_select; // [R3]
      lo_fwd   = (lo_idx || lo_dat) && !i_internal_clock_select; // [R3]
      acc_addr = lo_dat ? {1'b0, idx_lo_r} : idx_up_r; // [R2] [R5]
      mem_wr   = i_io_wr && ((lo_dat && lo_int) || up_dat); // [R4]
      mem_rd   = i_io_rd && ((lo_dat && lo_int) || up_dat);
      case (acc_addr)
         OFF_REG_A: rd_byte = {uip_r, reg_a[6:0]}; // [R12]
         OFF_REG_C: rd_byte = {irq_r, flags_r, 4'h0}; // [R18]
         OFF_REG_D: rd_byte = {batt_s_r[1], 7'h00}; // [R19]
         default:   rd_byte = mem_r[acc_addr];
      endcase
      nmi_gate_nxt = nmi_gate_r;
      idx_lo_nxt   = idx_lo_r;
      idx_up_nxt   = idx_up_r;
      if (i_io_wr && lo_idx && lo_int) begin
         nmi_gate_nxt = i_io_wdata[NMI_GATE_BIT]; // [R1]
         idx_lo_nxt   = i_io_wdata[6:0]; // [R2]
      end
      if (i_io_wr && up_idx) begin
         idx_up_nxt = i_io_wdata; // [R4]
      end
      rvalid_nxt = (i_io_rd && (lo_int || up_idx || up_dat)) ||
                   ext_rd_r;
      rdata_nxt  = rdata_r;
      if (ext_rd_r) begin
         rdata_nxt = ext_s2_r;
      end else if (i_io_rd && lo_idx && lo_int) begin
         rdata_nxt = {nmi_gate_r, idx_lo_r};
      end else if (i_io_rd && up_idx) begin
         rdata_nxt = idx_up_r;
      end else if (mem_rd) begin
         rdata_nxt = rd_byte;
      end
      ext_wr_nxt  = i_io_wr && lo_fwd; // [R3]
      ext_rd_nxt  = i_io_rd && lo_fwd && !ext_rd_r;
      ext_sel_nxt = lo_fwd ? lo_dat : ext_sel_r;
      ext_wd_nxt  = (i_io_wr && lo_fwd) ? i_io_wdata : ext_wd_r;
      serr_s_nxt  = {serr_s_r[0], i_serr_n};
      batt_s_nxt  = {batt_s_r[0], i_battery_good};
      ext_s1_nxt  = i_ext_rdata;
      ext_s2_nxt  = ext_s1_r;
      nmi_nxt     = !nmi_gate_r && !serr_s_r[1]; // [R1]
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         nmi_gate_r <= NMI_GATE_RST;
         idx_lo_r   <= 7'h00;
         idx_up_r   <= BYTE_RST;
         rdata_r    <= BYTE_RST;
         rvalid_r   <= 1'b0;
         nmi_r      <= 1'b0;
         ext_wr_r   <= 1'b0;
         ext_rd_r   <= 1'b0;
         ext_sel_r  <= 1'b0;
         ext_wd_r   <= BYTE_RST;
         serr_s_r   <= 2'h3;
         batt_s_r   <= 2'h0;
         ext_s1_r   <= BYTE_RST;
         ext_s2_r   <= BYTE_RST;
      end else begin
         nmi_gate_r <= nmi_gate_nxt;
         idx_lo_r   <= idx_lo_nxt;
         idx_up_r   <= idx_up_nxt;
         rdata_r    <= rdata_nxt;
         rvalid_r   <= rvalid_nxt;
         nmi_r      <= nmi_nxt;
         ext_wr_r   <= ext_wr_nxt;
         ext_rd_r   <= ext_rd_nxt;
         ext_sel_r  <= ext_sel_nxt;
         ext_wd_r   <= ext_wd_nxt;
         serr_s_r   <= serr_s_nxt;
         batt_s_r   <= batt_s_nxt;
         ext_s1_r   <= ext_s1_nxt;
         ext_s2_r   <= ext_s2_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Timekeeping, alarms and flags
   // -----------------------------------------------------------------
   always_comb begin : time_next
      logic       bcd, h24, pm, c_min, c_hr, c_day, c_mon, c_yr;
      logic       al_hit, base_tick, clr_c;
      logic [7:0] s, mi, hr, wd, md, mo, yr, cen, hs, h12;
      logic [14:0] mask;
      bcd = 1'b0; h24 = 1'b0; pm = 1'b0; c_min = 1'b0; c_hr = 1'b0;
      c_day = 1'b0; c_mon = 1'b0; c_yr = 1'b0; al_hit = 1'b0;
      base_tick = 1'b0; per_ev = 1'b0; clr_c = 1'b0; mask = 15'h0;
      s = 8'h0; mi = 8'h0; hr = 8'h0; wd = 8'h0; md = 8'h0; mo = 8'h0;
      yr = 8'h0; cen = 8'h0; hs = 8'h0; h12 = 8'h0;
      mem_nxt = mem_r;
      running = reg_a[6:4] == DIV_RUN; // [R13]
      set_inh = reg_b[B_SET_BIT];
      bcd     = !reg_b[B_DM_BIT]; // [R17]
      h24     = reg_b[B_H24_BIT]; // [R17]
      sec_cnt_nxt = !running ? '0 :
                    (sec_cnt_r == SW'(SEC_CYCLES - 1)) ? '0 :
                    sec_cnt_r + SW'(1);
      upd_tick = running && !set_inh && // [R15]
                 (sec_cnt_r == SW'(SEC_CYCLES - 1));
      uip_nxt  = running && !set_inh && // [R12]
                 (sec_cnt_r >= SW'(SEC_CYCLES - UIP_CYCLES));
      base_tick    = running && (base_cnt_r == BW'(BASE_CYCLES - 1));
      base_cnt_nxt = (!running || base_tick) ? '0 :
                     base_cnt_r + BW'(1);
      per_cnt_nxt  = !running ? 15'h0 :
                     base_tick ? per_cnt_r + 15'h1 : per_cnt_r;
      mask   = 15'((16'h1 << reg_a[3:0]) >> 1) - 15'h1;
      per_ev = base_tick && (reg_a[3:0] != 4'h0) && // [R14]
               ((per_cnt_nxt & mask) == 15'h0);
      // Advance the calendar, in binary, one second
      s  = to_bin(mem_r[OFF_SEC], bcd) + 8'd1; // [R7]
      c_min = s >= 8'd60;
      if (c_min) s = 8'd0;
      mi = to_bin(mem_r[OFF_MIN], bcd) + 8'(c_min); // [R7]
      c_hr = mi >= 8'd60;
      if (c_min && c_hr) mi = 8'd0;
      hs = mem_r[OFF_HOUR];
      if (h24) begin // [R8]
         hr = to_bin(hs, bcd);
      end else begin
         h12 = to_bin({1'b0, hs[6:0]}, bcd);
         hr  = ((h12 == 8'd12) ? 8'd0 : h12) +
               (hs[HOUR_PM_BIT] ? 8'd12 : 8'd0);
      end
      hr = hr + 8'(c_min && c_hr);
      c_day = c_min && c_hr && (hr >= 8'd24);
      if (c_day) hr = 8'd0;
      wd = to_bin(mem_r[OFF_WDAY], bcd) + 8'(c_day); // [R9]
      if (wd > 8'd7) wd = 8'd1;
      mo = to_bin(mem_r[OFF_MONTH], bcd);
      yr = to_bin(mem_r[OFF_YEAR], bcd);
      md = to_bin(mem_r[OFF_MDAY], bcd) + 8'(c_day); // [R9]
      c_mon = c_day && (md > month_len(mo, yr));
      if (c_mon) md = 8'd1;
      mo = mo + 8'(c_mon); // [R10]
      c_yr = c_mon && (mo > 8'd12);
      if (c_yr) mo = 8'd1;
      yr = yr + 8'(c_yr); // [R10]
      cen = to_bin(mem_r[OFF_CENTURY], bcd);
      if (c_yr && (yr >= 8'd100)) begin
         yr  = 8'd0;
         cen = cen + 8'd1; // [R11]
      end
      pm  = hr >= 8'd12;
      h12 = (hr == 8'd0) ? 8'd12 : (pm && hr != 8'd12) ? hr - 8'd12 : hr;
      hs  = h24 ? fr_bin(hr, bcd) :
            {pm, 7'(fr_bin(h12, bcd))}; // [R8]
      s   = fr_bin(s, bcd);
      mi  = fr_bin(mi, bcd);
      md  = fr_bin(md, bcd);
      mo  = fr_bin(mo, bcd);
      al_hit = ((mem_r[OFF_SEC_AL] >= ALARM_ANY) ||
                (mem_r[OFF_SEC_AL] == s)) &&
               ((mem_r[OFF_MIN_AL] >= ALARM_ANY) ||
                (mem_r[OFF_MIN_AL] == mi)) &&
               ((mem_r[OFF_HOUR_AL] >= ALARM_ANY) ||
                (mem_r[OFF_HOUR_AL] == hs)) &&
               ((mem_r[OFF_DATE_AL] == 8'h00) ||
                (mem_r[OFF_DATE_AL] == md)) && // [R11]
               ((mem_r[OFF_MONTH_AL] == 8'h00) ||
                (mem_r[OFF_MONTH_AL] == mo));
      if (upd_tick) begin // [R6]
         mem_nxt[OFF_SEC]     = s;
         mem_nxt[OFF_MIN]     = mi;
         mem_nxt[OFF_HOUR]    = hs;
         mem_nxt[OFF_WDAY]    = fr_bin(wd, bcd);
         mem_nxt[OFF_MDAY]    = md;
         mem_nxt[OFF_MONTH]   = mo;
         mem_nxt[OFF_YEAR]    = fr_bin(yr, bcd);
         mem_nxt[OFF_CENTURY] = fr_bin(cen, bcd);
      end
      if (mem_wr && acc_addr != OFF_REG_C && acc_addr != OFF_REG_D) begin
         mem_nxt[acc_addr] = i_io_wdata; // [R6] [R16]
      end
      clr_c = mem_rd && (acc_addr == OFF_REG_C);
      flags_nxt = (flags_r & {3{!clr_c}}) | // [R20]
                  {per_ev, upd_tick && al_hit, upd_tick}; // [R18]
      irq_nxt = |(flags_nxt & {reg_b[B_PIE_BIT], reg_b[B_AIE_BIT],
                               reg_b[B_UIE_BIT]}); // [R16] [R20]
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         for (int i = 0; i < 256; i++) begin
            mem_r[i] <= BYTE_RST;
         end
         mem_r[OFF_REG_A] <= REG_A_RST;
         mem_r[OFF_REG_B] <= REG_B_RST;
         sec_cnt_r  <= '0;
         base_cnt_r <= '0;
         per_cnt_r  <= 15'h0;
         flags_r    <= 3'h0;
         irq_r      <= 1'b0;
         uip_r      <= 1'b0;
      end else begin
         mem_r      <= mem_nxt;
         sec_cnt_r  <= sec_cnt_nxt;
         base_cnt_r <= base_cnt_nxt;
         per_cnt_r  <= per_cnt_nxt;
         flags_r    <= flags_nxt;
         irq_r      <= irq_nxt;
         uip_r      <= uip_nxt;
      end
   end

   assign o_io_rdata     = rdata_r;
   assign o_io_rvalid    = rvalid_r;
   assign o_nmi          = nmi_r;
   assign o_rtc_irq      = irq_r;
   assign o_ext_wr       = ext_wr_r;
   assign o_ext_rd       = ext_rd_r;
   assign o_ext_data_sel = ext_sel_r;
   assign o_ext_wdata    = ext_wd_r;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   sequence s_nmi_armed;
      !nmi_gate_r && !serr_s_r[1];
   endsequence
   sequence s_store_read;
      mem_rd && acc_addr >= 8'h0e && acc_addr < OFF_DATE_AL &&
      !(mem_wr);
   endsequence

   a_nmi_raise: assert property (s_nmi_armed |=> o_nmi) // [R1]
      else $error("nmi not raised");
   a_nmi_gated: assert property (nmi_gate_r |=> !o_nmi) // [R1]
      else $error("nmi passed while gated");
   a_store_read: assert property (s_store_read |=> // [R2]
      o_io_rvalid && o_io_rdata == $past(mem_r[acc_addr]))
      else $error("storage byte read wrong");
   a_fwd_write: assert property (i_io_wr && lo_fwd |=> // [R3]
      o_ext_wr && o_ext_wdata == $past(i_io_wdata) && !o_io_rvalid)
      else $error("lower write not forwarded");
   a_upper_off: assert property (i_io_rd && // [R4]
      (i_io_addr == P_UP_DATA) && !i_upper_pair_access_enable &&
      !ext_rd_r |=> !o_io_rvalid)
      else $error("upper pair answered while disabled");
   a_uip_read: assert property (mem_rd && acc_addr == OFF_REG_A // [R12]
      |=> o_io_rdata[A_UIP_BIT] == $past(uip_r))
      else $error("busy bit read wrong");
   a_div_stop: assert property (!running |-> !upd_tick && !uip_nxt) // [R13]
      else $error("clock ran with divider off");
   a_set_hold: assert property (set_inh && !mem_wr |=> // [R15]
      $stable(mem_r[OFF_SEC]) ##1 1'b1)
      else $error("seconds moved while inhibited");
   a_flag_clear: assert property (mem_rd && acc_addr == OFF_REG_C && // [R20]
      !upd_tick && !per_ev |=> flags_r == 3'h0)
      else $error("flags not cleared by read");
   a_irq_sum: assert property (##1 o_rtc_irq == |($past(flags_nxt) & // [R20]
      {$past(reg_b[B_PIE_BIT]), $past(reg_b[B_AIE_BIT]),
       $past(reg_b[B_UIE_BIT])}))
      else $error("summary flag wrong");
   a_batt_read: assert property (mem_rd && acc_addr == OFF_REG_D |=> // [R19]
      o_io_rdata[6:0] == 7'h00 && o_io_rdata[7] == $past(batt_s_r[1]))
      else $error("battery byte wrong");
endmodule : crp_rtc_port

// >>> sim/crp_ext_clock_model.sv
//--------------------------------------------------------------------
// Purpose: External clock chip behind the forwarded lower port pair
// Assumes: Strobes are one-cycle pulses from the block
// Notes:   Read data is driven steadily from the selected byte
//--------------------------------------------------------------------
`timescale 1ns/100ps
module crp_ext_clock_model (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   input  wire logic       i_data_sel,
   input  wire logic [7:0] i_wdata,
   output logic      [7:0] o_rdata
);
   logic [7:0] mem [0:127];
   logic [6:0] idx_r;
   // -----------------------------------------------------------------
   // Index and byte store
   // -----------------------------------------------------------------
   always @(posedge i_clk) begin
      if (i_rst) begin
         idx_r <= 7'h00;
      end else if (i_wr && !i_data_sel) begin
         idx_r <= i_wdata[6:0];
      end else if (i_wr && i_data_sel) begin
         mem[idx_r] <= i_wdata;
      end
   end
   assign o_rdata = (mem[idx_r] === 8'hxx) ? 8'h3c : mem[idx_r];
endmodule : crp_ext_clock_model

// >>> sim/cmos_rtc_port_block_tb.sv
//--------------------------------------------------------------------
// Purpose: Self-checking bench for the CMOS clock port block
// Assumes: Shortened second, busy and base tick counts
// Notes:   Inputs change on the falling clock edge
//--------------------------------------------------------------------
`timescale 1ns/100ps
module cmos_rtc_port_block_tb;
   import crp_pkg::*;
   logic i_clk, i_rst, i_io_wr, i_io_rd, sel, up_en, serr_n, batt;
   logic [15:0] i_io_addr;
   logic [7:0]  i_io_wdata, ext_rdata, o_io_rdata, o_ext_wdata, d, s;
   logic        o_io_rvalid, o_nmi, o_rtc_irq, o_ext_wr, o_ext_rd, ext_sel;
   logic        ok;
   logic [7:0]  ext_rd_n;
   int          miscompares, cmp_count, cyc, k;
   logic [7:0]  offs [9] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h07, 8'h08,
                             8'h09, 8'h7f, 8'h0b};
   logic [7:0]  vals [9] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12,
                             8'h99, 8'h19, 8'h32};
   logic [7:0]  nxt  [9] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01,
                             8'h00, 8'h20, 8'h32};
   crp_rtc_port #(.SEC_CYCLES(200), .UIP_CYCLES(20), .BASE_CYCLES(4))
      crp_rtc_port_i (.i_clk(i_clk), .i_rst(i_rst), .i_io_addr(i_io_addr),
      .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata),
      .i_internal_clock_select(sel), .i_upper_pair_access_enable(up_en),
      .i_serr_n(serr_n), .i_battery_good(batt), .i_ext_rdata(ext_rdata),
      .o_io_rdata(o_io_rdata), .o_io_rvalid(o_io_rvalid), .o_nmi(o_nmi),
      .o_rtc_irq(o_rtc_irq), .o_ext_wr(o_ext_wr), .o_ext_rd(o_ext_rd),
      .o_ext_data_sel(ext_sel), .o_ext_wdata(o_ext_wdata));
   crp_ext_clock_model crp_ext_clock_model_i (.i_clk(i_clk), .i_rst(i_rst),
      .i_wr(o_ext_wr), .i_rd(o_ext_rd), .i_data_sel(ext_sel),
      .i_wdata(o_ext_wdata), .o_rdata(ext_rdata));
   // -----------------------------------------------------------------
   // Clock and watchdog
   // -----------------------------------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (o_ext_rd === 1'b1) begin
         ext_rd_n <= ext_rd_n + 8'h01;
      end
      if (cyc == 20000) begin
         miscompares++;
         results();
      end
   end
   // -----------------------------------------------------------------
   // Access tasks
   // -----------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic io_wr(input logic [15:0] a, input logic [7:0] v);
      @(negedge i_clk);
      i_io_addr  = a;
      i_io_wdata = v;
      i_io_wr    = 1'b1;
      @(negedge i_clk);
      i_io_wr    = 1'b0;
   endtask : io_wr
   task automatic io_rd(input logic [15:0] a, output logic [7:0] v,
                        output logic got);
      @(negedge i_clk);
      i_io_addr = a;
      i_io_rd   = 1'b1;
      @(negedge i_clk);
      i_io_rd   = 1'b0;
      got = 1'b0;
      v   = 8'h00;
      for (int n = 0; n < 4 && !got; n++) begin
         if (o_io_rvalid === 1'b1) begin
            got = 1'b1;
            v   = o_io_rdata;
         end else begin
            @(negedge i_clk);
         end
      end
   endtask : io_rd
   task automatic cw(input logic [7:0] o, v);
      io_wr(P_LOW_INDEX, o);
      io_wr(P_LOW_DATA, v);
   endtask : cw
   task automatic cr(input logic [7:0] o, output logic [7:0] v);
      io_wr(P_LOW_INDEX, o);
      io_rd(P_LOW_DATA, v, ok);
   endtask : cr
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results
   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      {i_io_wr, i_io_rd, i_io_addr, i_io_wdata} = '0;
      {sel, up_en, serr_n, batt, i_rst} = 5'b11111;
      {miscompares, cmp_count, cyc} = '0;
      ext_rd_n = 8'h00;
      repeat (10) @(negedge i_clk);
      i_rst = 1'b0;
      io_rd(P_LOW_INDEX, d, ok);
      chk("gate_index", d, 8'h80);
      cr(OFF_REG_A, d);
      chk("reg_a", d & 8'h7f, REG_A_RST);
      cr(OFF_REG_B, d);
      chk("reg_b", d, REG_B_RST);
      cw(OFF_REG_D, 8'h00);
      cr(OFF_REG_D, d);
      chk("reg_d", d, 8'h80);
      cr(OFF_REG_C, d);
      chk("reg_c_low", d & 8'h0f, 8'h00);
      cw(8'h0e, 8'h55);
      cr(8'h0e, d);
      chk("store_lo", d, 8'h55);
      io_wr(P_UP_INDEX, 8'h0e);
      io_rd(P_UP_DATA, d, ok);
      chk("store_up", d, 8'h55);
      io_wr(P_UP_INDEX, 8'ha5);
      io_wr(P_UP_DATA, 8'h3e);
      io_rd(P_UP_DATA, d, ok);
      chk("upper_byte", d, 8'h3e);
      up_en = 1'b0;
      io_rd(P_UP_DATA, d, ok);
      chk("upper_off", {7'h00, ok}, 8'h00);
      up_en = 1'b1;
      serr_n = 1'b0;
      repeat (5) @(negedge i_clk);
      chk("nmi", {7'h00, o_nmi}, 8'h01);
      serr_n = 1'b1;
      // Load time under inhibit, then let one update roll everything
      cw(OFF_REG_B, 8'h82);
      cr(OFF_REG_C, d);
      for (k = 0; k < 3; k++) cw(8'(OFF_SEC_AL + 2 * k), ALARM_ANY);
      for (k = 0; k < 9; k++) cw(offs[k], vals[k]);
      for (k = 0; k < 400 && o_rtc_irq !== 1'b1; k++) @(negedge i_clk);
      for (k = 0; k < 9; k++) begin
         cr(offs[k], d);
         chk("rollover", d, nxt[k]);
      end
      cr(OFF_REG_C, d);
      chk("flags", d, 8'hb0);
      cr(OFF_REG_C, d);
      chk("flags_clr", d, 8'h00);
      chk("irq_pin", {7'h00, o_rtc_irq}, 8'h00);
      cw(OFF_REG_B, 8'h82);
      cr(OFF_SEC, s);
      repeat (250) @(negedge i_clk);
      cr(OFF_SEC, d);
      chk("inhibit", d, s);
      cw(OFF_REG_A, 8'h21);
      cw(OFF_REG_B, 8'h42);
      cr(OFF_REG_C, d);
      repeat (20) @(negedge i_clk);
      cr(OFF_REG_C, d);
      chk("periodic", d & 8'hc0, 8'hc0);
      cw(OFF_REG_A, 8'ha0);
      s = 8'h00;
      for (k = 0; k < 150 && s != 8'h81; k++) begin
         cr(OFF_REG_A, d);
         s = s | (d[7] ? 8'h80 : 8'h01);
      end
      chk("busy_seen", s, 8'h81);
      cw(OFF_REG_A, 8'h00);
      cr(OFF_SEC, s);
      repeat (250) @(negedge i_clk);
      cr(OFF_SEC, d);
      chk("div_stop", d, s);
      sel = 1'b0;
      io_wr(P_LOW_INDEX, 8'h21);
      io_wr(P_LOW_DATA, 8'h6b);
      repeat (6) @(negedge i_clk);
      io_rd(P_LOW_DATA, d, ok);
      chk("forwarded", d, 8'h6b);
      chk("ext_rd", ext_rd_n, 8'h01);
      results();
   end
endmodule : cmos_rtc_port_block_tb
